// ---- design/nsu_pkg.sv ----
// package for the memory security unlock block: map, fields, modes
//
// Summary of operation
// - every reset copies the options byte into the security copy register
// - options byte also readable at paged window address when page select is top
// - options byte programmed only by aligned word write to even address below
// - erase or program of options byte refused while its sector is protected
// - key enable field enables backdoor only for pattern 10
// - security field means unsecured only for pattern 10, else secured
// - newly programmed security value takes effect only at next reset
// - secured normal single chip: debug port off, normal memory commands allowed
// - secured special single chip: mass erase only; unless erased at reset, no firmware debug and hardware debug registers only
// - secured expanded: debug off, no external access, no visibility or pipe status
// - secured normal expanded: no memory commands from external code
// - backdoor only in normal modes with valid key and key enable set
// - full key match forces copy field to 10, options byte untouched
// - any mismatching key word leaves the device secured
// - key words from the debug port are never accepted
// - options byte reprogrammed unsecured gives unsecured state at next reset
// - secured special single chip reset with unerased memory: hardware debug only
// - secured special single chip reset with all erased: all debug commands enabled
package nsu_pkg;

   // memory addresses seen by the block
   localparam logic [15:0] ADDR_OPTIONS      = 16'hff0f;
   localparam logic [15:0] ADDR_OPTIONS_WORD = 16'hff0e;
   localparam logic [15:0] ADDR_OPTIONS_PAGE = 16'hbf0f;
   localparam logic [7:0]  PAGE_TOP          = 8'h3f;
   localparam logic [15:0] ADDR_KEY_BASE     = 16'hff00;
   localparam logic [15:0] ADDR_SECTOR_LO    = 16'hfe00;
   localparam logic [15:0] KEY_ALL_ZERO      = 16'h0000;
   localparam logic [15:0] KEY_ALL_ONE       = 16'hffff;

   // field layout of the options byte
   localparam int          SINGLE_KEY_UNLOCK_ENABLE_MSB         = 7;
   localparam int          SINGLE_KEY_UNLOCK_ENABLE_LSB         = 6;
   localparam int          SEC_MSB           = 1;
   localparam int          SEC_LSB           = 0;
   localparam logic [1:0]  PATTERN_OPEN      = 2'h2;

   // memory commands
   localparam logic [7:0]  CMD_ERASE_VERIFY  = 8'h05;
   localparam logic [7:0]  CMD_PROGRAM       = 8'h20;
   localparam logic [7:0]  CMD_SECTOR_ERASE  = 8'h40;
   localparam logic [7:0]  CMD_MASS_ERASE    = 8'h41;
   localparam logic [7:0]  CMD_SECTOR_MODIFY = 8'h60;

   // apb register map, byte addresses
   localparam logic [7:0]  REG_COPY          = 8'h00;
   localparam logic [7:0]  REG_CONFIG        = 8'h04;
   localparam logic [7:0]  REG_PAGE          = 8'h08;
   localparam logic [7:0]  REG_KEYWORD       = 8'h0c;
   localparam logic [7:0]  REG_STATUS        = 8'h10;
   localparam logic [7:0]  REG_OPTREAD       = 8'h14;
   localparam int          CFG_KEY_WRITE_ACCESS_BIT    = 5;
   localparam int          CFG_SECTPROT_BIT  = 0;

   // reset values
   localparam logic [7:0]  RST_CONFIG        = 8'h00;
   localparam logic [7:0]  RST_PAGE          = 8'h00;
   localparam logic [7:0]  RST_COPY          = 8'hff;

   typedef enum logic [1:0] {
      NSU_NORMAL_SINGLE,
      NSU_SPECIAL_SINGLE,
      NSU_NORMAL_EXPANDED,
      NSU_SPECIAL_EXPANDED
   } nsu_mode_t;

   typedef enum logic [1:0] {
      NSU_LOAD,
      NSU_RUN
   } nsu_phase_t;

   // access restrictions shown to the rest of the chip
   typedef struct packed {
      logic dbgEnable;
      logic dbgFirmwareEnable;
      logic dbgRegsOnly;
      logic extAccessEnable;
      logic visibilityEnable;
      logic pipeStatusEnable;
   } nsu_gate_t;

   // a memory command offered by the controller for approval
   typedef struct packed {
      logic       valid;
      logic [7:0] code;
      logic [15:0] addr;
      logic       fromExternal;
   } nsu_cmd_t;

endpackage

// ---- design/nsu_security_unlock.sv ----
// security copy, access gating and backdoor key unlock of the memory controller
`timescale 1ns/1ns
`default_nettype none
module nsu_security_unlock #(
   parameter int KEY_WORDS = 4
) (
   input  wire logic              mclk,
   input  wire logic              nrst,
   // apb slave
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [7:0]        paddr,
   input  wire logic [31:0]       pwdata,
   output logic                   pready,
   output logic [31:0]            prdata,
   output logic                   pslverr,
   // nonvolatile side
   input  wire logic [7:0]        optionsByte,
   input  wire logic [16*KEY_WORDS-1:0] storedKey,
   input  wire logic              allErased,
   input  wire logic [1:0]        opMode,
   input  wire logic              dbgWriteSource,
   // command approval
   input  wire nsu_pkg::nsu_cmd_t memCmd,
   output logic                   cmdAccept,
   output logic                   cmdReject,
   // gating and state
   output nsu_pkg::nsu_gate_t     gate,
   output logic                   secured,
   output logic [7:0]             securityCopy
);

   initial begin
      if (KEY_WORDS != 4) $error("key length must be four words");
   end

   typedef struct packed {
      nsu_pkg::nsu_phase_t phase;
      logic [7:0]  copy;
      logic [7:0]  cfg;
      logic [7:0]  page;
      logic [1:0]  keyIdx;
      logic        keyOk;
      logic        keyTried;
      logic        keyFailed;
      logic        erasedAtReset;
      logic [31:0] rdata;
      logic        accept;
      logic        reject;
   } nsu_state_t;

   nsu_state_t s_q;
   nsu_state_t s_d;

   ////////////////////////////////////////////////////////////////////////////
   // decode

   nsu_pkg::nsu_mode_t mode;
   logic       isSecure;
   logic       keyEnabled;
   logic       keyValid;
   logic       apbWr;
   logic       apbRd;
   logic [15:0] keyWord;
   logic       cmdAllowed;
   logic       hitsOptions;
   logic       waited_q;

   assign mode       = nsu_pkg::nsu_mode_t'(opMode);
   assign isSecure   = s_q.copy[nsu_pkg::SEC_MSB:nsu_pkg::SEC_LSB] != nsu_pkg::PATTERN_OPEN;
   assign keyEnabled = s_q.copy[nsu_pkg::SINGLE_KEY_UNLOCK_ENABLE_MSB:nsu_pkg::SINGLE_KEY_UNLOCK_ENABLE_LSB] == nsu_pkg::PATTERN_OPEN;
   // a write lands once, at the edge that completes the access
   assign apbWr      = psel && penable && pwrite && waited_q;
   // read data is captured in the first access cycle so it stands with pready
   assign apbRd      = psel && penable && !pwrite && !waited_q;
   assign keyWord    = storedKey[16*s_q.keyIdx +: 16];

   // a key is usable only if no word is all zeros or all ones
   always_comb begin
      keyValid = 1'b1;
      for (int i = 0; i < KEY_WORDS; i++) begin
         if (storedKey[16*i +: 16] == nsu_pkg::KEY_ALL_ZERO ||
             storedKey[16*i +: 16] == nsu_pkg::KEY_ALL_ONE) begin
            keyValid = 1'b0;
         end
      end
   end

   // the options byte sits in the top sector
   assign hitsOptions = memCmd.addr >= nsu_pkg::ADDR_SECTOR_LO;

   always_comb begin
      cmdAllowed = 1'b1;
      if (isSecure) begin
         unique case (mode)
            nsu_pkg::NSU_NORMAL_SINGLE: begin
               cmdAllowed = memCmd.code == nsu_pkg::CMD_PROGRAM ||
                            memCmd.code == nsu_pkg::CMD_MASS_ERASE ||
                            memCmd.code == nsu_pkg::CMD_SECTOR_ERASE ||
                            memCmd.code == nsu_pkg::CMD_ERASE_VERIFY ||
                            memCmd.code == nsu_pkg::CMD_SECTOR_MODIFY;
            end
            nsu_pkg::NSU_SPECIAL_SINGLE: begin
               cmdAllowed = memCmd.code == nsu_pkg::CMD_MASS_ERASE;
            end
            nsu_pkg::NSU_NORMAL_EXPANDED: begin
               cmdAllowed = !memCmd.fromExternal;
            end
            nsu_pkg::NSU_SPECIAL_EXPANDED: begin
               cmdAllowed = 1'b1;
            end
         endcase
      end
      // protected top sector blocks erase and program of the options byte
      if (s_q.cfg[nsu_pkg::CFG_SECTPROT_BIT] && hitsOptions &&
          memCmd.code != nsu_pkg::CMD_ERASE_VERIFY) begin
         cmdAllowed = 1'b0;
      end
      // program must target an even address
      if (memCmd.code == nsu_pkg::CMD_PROGRAM && memCmd.addr[0]) begin
         cmdAllowed = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state

   always_comb begin
      s_d = s_q;
      s_d.accept = 1'b0;
      s_d.reject = 1'b0;
      s_d.rdata  = 32'h0;
      unique case (s_q.phase)
         nsu_pkg::NSU_LOAD: begin
            // only a reset loads the copy, so later programming waits for it
            s_d.copy          = optionsByte;
            s_d.erasedAtReset = allErased;
            s_d.phase         = nsu_pkg::NSU_RUN;
         end
         nsu_pkg::NSU_RUN: begin
            if (apbWr && paddr == nsu_pkg::REG_CONFIG) begin
               s_d.cfg = pwdata[7:0];
               // leaving key access ends the attempt
               if (s_q.cfg[nsu_pkg::CFG_KEY_WRITE_ACCESS_BIT] && !pwdata[nsu_pkg::CFG_KEY_WRITE_ACCESS_BIT]) begin
                  if (s_q.keyTried && s_q.keyOk && s_q.keyIdx == 2'h0) begin
                     s_d.copy[nsu_pkg::SEC_MSB:nsu_pkg::SEC_LSB] = nsu_pkg::PATTERN_OPEN;
                  end else if (s_q.keyTried) begin
                     s_d.keyFailed = 1'b1;
                  end
                  s_d.keyTried = 1'b0;
               end
               if (!s_q.cfg[nsu_pkg::CFG_KEY_WRITE_ACCESS_BIT] && pwdata[nsu_pkg::CFG_KEY_WRITE_ACCESS_BIT]) begin
                  s_d.keyIdx    = 2'h0;
                  s_d.keyOk     = 1'b1;
                  s_d.keyTried  = 1'b0;
                  s_d.keyFailed = 1'b0;
               end
            end
            if (apbWr && paddr == nsu_pkg::REG_PAGE) begin
               s_d.page = pwdata[7:0];
            end
            // key words are taken in order from application code only
            if (apbWr && paddr == nsu_pkg::REG_KEYWORD &&
                s_q.cfg[nsu_pkg::CFG_KEY_WRITE_ACCESS_BIT] && !dbgWriteSource) begin
               if (!(keyEnabled && keyValid && isSecure &&
                     (mode == nsu_pkg::NSU_NORMAL_SINGLE || mode == nsu_pkg::NSU_NORMAL_EXPANDED)) ||
                   pwdata[15:0] != keyWord) begin
                  s_d.keyOk = 1'b0;
               end
               if (s_q.keyTried && s_q.keyIdx == 2'h0) begin
                  s_d.keyOk = 1'b0;
               end
               s_d.keyTried = 1'b1;
               s_d.keyIdx   = s_q.keyIdx + 2'h1;
            end
            if (apbRd) begin
               unique case (paddr)
                  nsu_pkg::REG_COPY:    s_d.rdata = {24'h0, s_q.copy};
                  nsu_pkg::REG_CONFIG:  s_d.rdata = {24'h0, s_q.cfg};
                  nsu_pkg::REG_PAGE:    s_d.rdata = {24'h0, s_q.page};
                  nsu_pkg::REG_STATUS:  s_d.rdata = {27'h0, s_q.keyFailed, s_q.erasedAtReset,
                                                     keyValid, keyEnabled, isSecure};
                  nsu_pkg::REG_OPTREAD: s_d.rdata = (s_q.page == nsu_pkg::PAGE_TOP) ?
                                                    {24'h0, optionsByte} : 32'h0;
                  default:              s_d.rdata = 32'h0;
               endcase
            end
            if (memCmd.valid) begin
               s_d.accept = cmdAllowed;
               s_d.reject = !cmdAllowed;
            end
         end
         default: s_d.phase = nsu_pkg::NSU_LOAD;
      endcase
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         s_q        <= '0;
         s_q.phase  <= nsu_pkg::NSU_LOAD;
         s_q.copy   <= nsu_pkg::RST_COPY;
         s_q.cfg    <= nsu_pkg::RST_CONFIG;
         s_q.page   <= nsu_pkg::RST_PAGE;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs

   logic mapped;
   assign mapped = paddr == nsu_pkg::REG_COPY || paddr == nsu_pkg::REG_CONFIG ||
                   paddr == nsu_pkg::REG_PAGE || paddr == nsu_pkg::REG_KEYWORD ||
                   paddr == nsu_pkg::REG_STATUS || paddr == nsu_pkg::REG_OPTREAD;

   // one wait state: read data is registered in the first access cycle
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         waited_q <= 1'b0;
      end else begin
         waited_q <= psel && penable && !waited_q;
      end
   end

   assign pready       = waited_q;
   assign prdata       = s_q.rdata;
   assign pslverr      = waited_q && !mapped;
   assign cmdAccept    = s_q.accept;
   assign cmdReject    = s_q.reject;
   assign secured      = isSecure;
   assign securityCopy = s_q.copy;

   always_comb begin
      gate = '1;
      if (isSecure) begin
         unique case (mode)
            nsu_pkg::NSU_NORMAL_SINGLE: begin
               gate.dbgEnable         = 1'b0;
               gate.dbgFirmwareEnable = 1'b0;
            end
            nsu_pkg::NSU_SPECIAL_SINGLE: begin
               // erased part opens every debug command
               gate.dbgFirmwareEnable = s_q.erasedAtReset;
               gate.dbgRegsOnly       = !s_q.erasedAtReset;
            end
            nsu_pkg::NSU_NORMAL_EXPANDED, nsu_pkg::NSU_SPECIAL_EXPANDED: begin
               gate.dbgEnable         = 1'b0;
               gate.dbgFirmwareEnable = 1'b0;
               gate.extAccessEnable   = 1'b0;
               gate.visibilityEnable  = 1'b0;
               gate.pipeStatusEnable  = 1'b0;
            end
         endcase
      end else begin
         gate.dbgRegsOnly = 1'b0;
      end
   end

endmodule
`default_nettype wire

// ---- tb/nsu_nvm_model.sv ----
// far-side nonvolatile array model: options byte, backdoor key, erase state
`timescale 1ns/1ns
`default_nettype none
module nsu_nvm_model #(
   parameter logic [63:0] KEY = 64'h1234_a5a5_0f0f_7e81
) (
   input  wire logic        mclk,
   input  wire logic        massErase,
   input  wire logic        progEn,
   input  wire logic [15:0] progWord,
   input  wire logic        loadEn,
   input  wire logic [7:0]  loadOpt,
   output logic [7:0]       optionsByte,
   output logic [63:0]      storedKey,
   output logic             allErased
);
   ////////////////////////////////////////////////////////////////
   // cells only clear bits, so a program without prior erase corrupts
   always_ff @(posedge mclk) begin
      if (massErase) begin
         optionsByte <= 8'hff;
         allErased   <= 1'b1;
      end else if (progEn) begin
         optionsByte <= optionsByte & progWord[7:0];
         allErased   <= 1'b0;
      end else if (loadEn) begin
         optionsByte <= loadOpt;
         allErased   <= 1'b0;
      end
   end
   assign storedKey = allErased ? {4{16'hffff}} : KEY;
endmodule
`default_nettype wire

// ---- tb/nsu_security_unlock_props.sv ----
// concurrent checks on the security unlock block ports
`timescale 1ns/1ns
`default_nettype none
module nsu_security_unlock_props (
   input wire logic               mclk,
   input wire logic               nrst,
   input wire logic [7:0]         optionsByte,
   input wire logic               allErased,
   input wire logic [1:0]         opMode,
   input wire nsu_pkg::nsu_cmd_t  memCmd,
   input wire logic               cmdAccept,
   input wire logic               cmdReject,
   input wire nsu_pkg::nsu_gate_t gate,
   input wire logic               secured,
   input wire logic [7:0]         securityCopy
);
   logic loadPend;
   logic erasedSeen;
   // erase result as the block should have sampled it at release
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         loadPend   <= 1'b1;
         erasedSeen <= 1'b0;
      end else if (loadPend) begin
         loadPend   <= 1'b0;
         erasedSeen <= allErased;
      end
   end
   ////////////////////////////////////////////////////////////////
   default clocking dc @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_copy_load: assert property ($rose(nrst) |=> securityCopy == $past(optionsByte))
      else $error("copy not loaded at release");
   a_sec_decode: assert property (secured == (securityCopy[1:0] != nsu_pkg::PATTERN_OPEN))
      else $error("secured flag wrong");
   a_copy_hold: assert property ($past(nrst, 2) && $past(nrst) && securityCopy != $past(securityCopy)
      |-> securityCopy == {$past(securityCopy[7:2]), 2'h2}) else $error("copy changed between resets");
   a_unlock_cond: assert property ($past(nrst, 2) && $past(nrst) && $fell(secured)
      |-> securityCopy[7:6] == 2'h2 && !opMode[0]) else $error("unlock without enable");
   a_single_dbg: assert property (secured && opMode == 2'h0 |-> !gate.dbgEnable)
      else $error("debug open while secured");
   a_special_fw: assert property (!loadPend && secured && opMode == 2'h1 |-> gate.dbgFirmwareEnable == erasedSeen)
      else $error("firmware debug gate wrong");
   a_expanded_gate: assert property (secured && opMode[1] |-> !(gate.dbgEnable || gate.extAccessEnable
      || gate.visibilityEnable || gate.pipeStatusEnable)) else $error("expanded gate open");
   a_special_cmd: assert property (secured && opMode == 2'h1 && memCmd.valid
      && memCmd.code != nsu_pkg::CMD_MASS_ERASE |=> cmdReject && !cmdAccept) else $error("command not refused");
   a_ext_cmd: assert property (secured && opMode == 2'h2 && memCmd.valid && memCmd.fromExternal
      |=> cmdReject && !cmdAccept) else $error("external command not refused");
endmodule
bind nsu_security_unlock nsu_security_unlock_props i_nsu_security_unlock_props (.mclk(mclk), .nrst(nrst),
   .optionsByte(optionsByte), .allErased(allErased), .opMode(opMode), .memCmd(memCmd), .cmdAccept(cmdAccept),
   .cmdReject(cmdReject), .gate(gate), .secured(secured), .securityCopy(securityCopy));
`default_nettype wire

// ---- tb/nsu_security_unlock_tb_top.sv ----
// self-checking bench for the memory security unlock block
`timescale 1ns/1ns
`default_nettype none
module nsu_security_unlock_tb_top;
   localparam logic [63:0] KEY = 64'h1234_a5a5_0f0f_7e81;
   logic               mclk, nrst, psel, penable, pwrite, pready, pslverr, perr, allErased, dbgWriteSource;
   logic               cmdAccept, cmdReject, secured, massErase, progEn, loadEn;
   logic [1:0]         opMode;
   logic [7:0]         paddr, optionsByte, securityCopy, loadOpt;
   logic [15:0]        progWord;
   logic [31:0]        pwdata, prdata, rd;
   logic [63:0]        storedKey;
   logic [7:0]         codes [5] = '{8'h05, 8'h20, 8'h40, 8'h41, 8'h60};
   nsu_pkg::nsu_cmd_t  memCmd;
   nsu_pkg::nsu_gate_t gate;
   int                 n_mismatch, tests_run;

   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   nsu_security_unlock i_nsu_security_unlock (.mclk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
      .prdata, .pslverr, .optionsByte, .storedKey, .allErased, .opMode, .dbgWriteSource, .memCmd, .cmdAccept,
      .cmdReject, .gate, .secured, .securityCopy);
   nsu_nvm_model #(.KEY(KEY)) i_nsu_nvm_model (.mclk, .massErase, .progEn, .progWord, .loadEn, .loadOpt,
      .optionsByte, .storedKey, .allErased);
   ////////////////////////////////////////////////////////////////
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (e !== g) begin
         $display("[ERR] %s expected %h seen %h", nm, e, g);
         n_mismatch++;
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         n_mismatch++;
         end_sim;
      end
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic do_reset(input logic [7:0] o, input logic [1:0] m, input logic ld);
      nrst <= 1'b0; opMode <= m; loadOpt <= o; loadEn <= ld;
      @(posedge mclk);
      loadEn <= 1'b0;
      @(posedge mclk);
      nrst <= 1'b1;
      repeat (2) @(posedge mclk);
   endtask
   task automatic unlock(input int bad, input logic dbg, input logic acc);
      apb(1'b1, nsu_pkg::REG_CONFIG, 32'(acc) << nsu_pkg::CFG_KEY_WRITE_ACCESS_BIT);
      dbgWriteSource <= dbg;
      for (int i = 0; i < 4; i++)
         apb(1'b1, nsu_pkg::REG_KEYWORD, {16'h0, KEY[16*i +: 16] ^ 16'(i == bad)});
      dbgWriteSource <= 1'b0;
      apb(1'b1, nsu_pkg::REG_CONFIG, 32'h0);
   endtask
   task automatic cmd(input logic [7:0] c, input logic [15:0] a, input logic x, input logic ok);
      memCmd <= '{1'b1, c, a, x};
      @(posedge mclk);
      memCmd.valid <= 1'b0;
      @(posedge mclk);
      check("cmdAccept", 32'(ok), 32'(cmdAccept));
      check("cmdReject", 32'(!ok), 32'(cmdReject));
   endtask
   // only normal modes may unlock, and only with the key enable pattern
   function automatic logic exp_sec(input logic [7:0] o, input logic [1:0] m, input logic good);
      return o[1:0] != 2'h2 && !(good && o[7:6] == 2'h2 && !m[0]);
   endfunction
   ////////////////////////////////////////////////////////////////
   initial begin
      int bad;
      logic [7:0] o;
      logic [1:0] m;
      n_mismatch = 0; tests_run = 0; nrst = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; dbgWriteSource = 1'b0; memCmd = '0; opMode = 2'h0; massErase = 1'b0;
      progEn = 1'b0; progWord = 16'h0; loadEn = 1'b1; loadOpt = 8'hff;
      o = 8'($urandom(40));
      repeat (10) @(posedge mclk);
      for (int t = 0; t < 24; t++) begin
         o = 8'($urandom);
         m = 2'($urandom % 3);
         bad = ($urandom % 3 == 0) ? int'($urandom % 4) : 4;
         if (t < 16) o = {t[3:2], o[5:2], t[1:0]};
         else begin
            o = {2'h2, o[5:2], 2'h3};
            m = 2'h0;
            bad = (t < 18) ? 4 : bad;
         end
         do_reset(o, m, 1'b1);
         check("securityCopy", {24'h0, o}, {24'h0, securityCopy});
         apb(1'b0, nsu_pkg::REG_COPY, 32'h0);
         check("copy register", {24'h0, o}, rd);
         unlock(bad, t == 16, t != 17);
         check("secured", 32'(exp_sec(o, m, bad == 4 && t != 16 && t != 17)), 32'(secured));
      end
      $display("test unlock done");
      apb(1'b0, nsu_pkg::REG_CONFIG, 32'h0);
      check("config reset", 32'(nsu_pkg::RST_CONFIG), rd);
      apb(1'b1, nsu_pkg::REG_PAGE, {24'h0, nsu_pkg::PAGE_TOP});
      apb(1'b0, nsu_pkg::REG_OPTREAD, 32'h0);
      check("paged options", {24'h0, o}, rd);
      apb(1'b0, 8'h18, 32'h0);
      check("unmapped pslverr", 32'h1, 32'(perr));
      do_reset(8'hbf, 2'h0, 1'b1);
      unlock(4, 1'b0, 1'b1);
      do_reset(8'hbf, 2'h0, 1'b0);
      check("secured again", 32'h1, 32'(secured));
      $display("test registers done");
      for (int k = 0; k < 3; k++) begin
         do_reset(8'hff, 2'(k), 1'b1);
         for (int c = 0; c < 5; c++)
            cmd(codes[c], 16'($urandom % 16'hfe00) & 16'hfffe, k == 2, k == 0 || (k == 1 && c == 3));
         if (k != 1) check("dbgEnable", 32'h0, 32'(gate.dbgEnable));
         else check("dbgFirmwareEnable", 32'h0, 32'(gate.dbgFirmwareEnable));
      end
      do_reset(8'hff, 2'h0, 1'b1);
      apb(1'b1, nsu_pkg::REG_CONFIG, 32'h1);
      cmd(nsu_pkg::CMD_PROGRAM, nsu_pkg::ADDR_OPTIONS_WORD, 1'b0, 1'b0);
      $display("test commands done");
      do_reset(8'hff, 2'h1, 1'b1);
      cmd(nsu_pkg::CMD_MASS_ERASE, 16'h0, 1'b0, 1'b1);
      massErase <= 1'b1;
      @(posedge mclk);
      massErase <= 1'b0;
      do_reset(8'hff, 2'h1, 1'b0);
      check("dbgFirmwareEnable", 32'h1, 32'(gate.dbgFirmwareEnable));
      progEn <= 1'b1; progWord <= 16'hffbe;
      @(posedge mclk);
      progEn <= 1'b0;
      @(posedge mclk);
      check("secured before reset", 32'h1, 32'(secured));
      do_reset(8'hff, 2'h0, 1'b0);
      check("secured after reset", 32'h0, 32'(secured));
      $display("test erase done");
      end_sim;
   end
   initial begin
      repeat (20000) @(posedge mclk);
      n_mismatch++;
      end_sim;
   end
endmodule
`default_nettype wire
